// ==== etl_regs.vh ====
// Constants for the external torque limit select block: register
// offsets, field positions, reset values and ranges.
// Assumes a 4-bit word address and 16-bit register data.
`ifndef ETL_REGS_VH
`define ETL_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ETL_A_FWD_INT 4'h0
`define ETL_A_REV_INT 4'h1
`define ETL_A_FWD_EXT 4'h2
`define ETL_A_REV_EXT 4'h3
`define ETL_A_IN_ASSIGN 4'h4
`define ETL_A_OUT_ASSIGN 4'h5
`define ETL_A_ENC_USAGE 4'h6
`define ETL_A_STATUS 4'h7
`define ETL_A_POS_LO 4'h8
`define ETL_A_POS_HI 4'h9
`define ETL_A_DIR_SEL 4'ha
`define ETL_A_CTRL 4'hb

// ----------------------------------------------------------------
// Limits in 1% steps of rated torque
// ----------------------------------------------------------------
`define ETL_LIM_W 10
`define ETL_LIM_MAX 10'h320
`define ETL_INT_RST 10'h320
`define ETL_EXT_RST 10'h064
`define ETL_TRQ_W 12

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ETL_IN_FWD_LSB 8
`define ETL_IN_REV_LSB 12
`define ETL_IN_ASSIGN_RST 16'h8800
`define ETL_OUT_ASSIGN_RST 16'h0000
`define ETL_ENC_LSB 8
`define ETL_ENC_USAGE_RST 16'h0000
`define ETL_DIR_SEL_RST 16'h0000
`define ETL_N_IN_TERM 8
`define ETL_N_OUT_TERM 4
`define ETL_TURN_BITS 20

// Encoder usage digit and effective modes
`define ETL_ENC_OWN 4'h0
`define ETL_ENC_INC 4'h1
`define ETL_ENC_ABS1 4'h2
`define ETL_MODE_INC 2'h0
`define ETL_MODE_ABS1 2'h1
`define ETL_MODE_ABSM 2'h2

`endif

// ==== etl_term_sel.v ====
// Input terminal selector: picks one terminal bit by a digit field.
// Assumes terminals are already synchronous to the core clock.
`timescale 1ns/10ps
`include "etl_regs.vh"

module etl_term_sel (
  input wire [`ETL_N_IN_TERM-1:0] term_i,
  input wire [3:0] digit_i,
  output wire active_o
);

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Digits past the last terminal leave the signal unassigned (off)
  assign active_o = (digit_i < `ETL_N_IN_TERM) ? term_i[digit_i[2:0]] : 1'b0;

endmodule // etl_term_sel

// ==== etl_limit_sel.v ====
// Per-direction torque limit selection.
// Assumes all settings are already held within the legal range.
`timescale 1ns/10ps
`include "etl_regs.vh"

module etl_limit_sel (
  input wire [`ETL_LIM_W-1:0] int_lim_i,
  input wire [`ETL_LIM_W-1:0] ext_lim_i,
  input wire ext_req_i,
  input wire [`ETL_LIM_W-1:0] motor_max_i,
  output wire [`ETL_LIM_W-1:0] limit_o
);

  function [`ETL_LIM_W-1:0] lim_min;
    input [`ETL_LIM_W-1:0] a;
    input [`ETL_LIM_W-1:0] b;
    begin
      lim_min = (a < b) ? a : b;
    end
  endfunction

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  wire [`ETL_LIM_W-1:0] sel_lim;

  // Internal limit always applies; external only narrows it
  assign sel_lim = ext_req_i ? lim_min(int_lim_i, ext_lim_i) : int_lim_i;
  assign limit_o = lim_min(sel_lim, motor_max_i);

endmodule // etl_limit_sel

// ==== etl_top.v ====
// Top of the external torque limit select block: register port,
// limit selection, torque clamp, status routing and position keeping.
// Assumes all inputs are synchronous to core_clk_i and that the host
// drives the register strobes one cycle wide.
`timescale 1ns/10ps
`include "etl_regs.vh"

module etl_top (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  input wire [`ETL_N_IN_TERM-1:0] in_term_i,
  output reg [`ETL_N_OUT_TERM-1:0] out_term_o,
  input wire [`ETL_LIM_W-1:0] motor_max_i,
  input wire trq_vld_i,
  input wire signed [`ETL_TRQ_W-1:0] trq_cmd_i,
  output reg trq_vld_o,
  output reg signed [`ETL_TRQ_W-1:0] trq_out_o,
  output reg torque_limited_flag_o,
  input wire [1:0] enc_type_i,
  input wire [31:0] abs_pos_i,
  input wire pos_step_i,
  input wire pos_dir_i
);

  // Settings above the range are held at the top of the range
  function [`ETL_LIM_W-1:0] sat_lim;
    input [15:0] v;
    begin
      sat_lim = (v > {6'h00, `ETL_LIM_MAX}) ? `ETL_LIM_MAX : v[`ETL_LIM_W-1:0];
    end
  endfunction

  // Magnitude of a signed torque, kept at the full torque width
  function [`ETL_TRQ_W-1:0] trq_mag;
    input [`ETL_TRQ_W-1:0] t;
    begin
      trq_mag = t[`ETL_TRQ_W-1] ? (~t + 12'h001) : t;
    end
  endfunction

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  reg [`ETL_LIM_W-1:0] fwd_internal_limit;
  reg [`ETL_LIM_W-1:0] rev_internal_limit;
  reg [`ETL_LIM_W-1:0] fwd_external_limit;
  reg [`ETL_LIM_W-1:0] rev_external_limit;
  reg [15:0] input_assign_param;
  reg [15:0] output_assign_param;
  reg [15:0] encoder_usage_param;
  reg [15:0] direction_select_param;
  reg restart_req;

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fwd_internal_limit <= `ETL_INT_RST;
      rev_internal_limit <= `ETL_INT_RST;
      fwd_external_limit <= `ETL_EXT_RST;
      rev_external_limit <= `ETL_EXT_RST;
      input_assign_param <= `ETL_IN_ASSIGN_RST;
      output_assign_param <= `ETL_OUT_ASSIGN_RST;
      encoder_usage_param <= `ETL_ENC_USAGE_RST;
      direction_select_param <= `ETL_DIR_SEL_RST;
      restart_req <= 1'b0;
    end else begin
      restart_req <= 1'b0;
      if (wr_i) begin
        case (addr_i)
          `ETL_A_FWD_INT: fwd_internal_limit <= sat_lim(wdata_i);
          `ETL_A_REV_INT: rev_internal_limit <= sat_lim(wdata_i);
          `ETL_A_FWD_EXT: fwd_external_limit <= sat_lim(wdata_i);
          `ETL_A_REV_EXT: rev_external_limit <= sat_lim(wdata_i);
          `ETL_A_IN_ASSIGN: input_assign_param <= wdata_i;
          `ETL_A_OUT_ASSIGN: output_assign_param <= wdata_i;
          `ETL_A_ENC_USAGE: encoder_usage_param <= wdata_i;
          `ETL_A_DIR_SEL: direction_select_param <= wdata_i;
          `ETL_A_CTRL: restart_req <= wdata_i[0];
          default: restart_req <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // External request inputs
  // ----------------------------------------------------------------
  wire fwd_req_raw;
  wire rev_req_raw;
  reg fwd_ext_limit_req;
  reg rev_ext_limit_req;

  etl_term_sel u_fwd_term (
    .term_i(in_term_i),
    .digit_i(input_assign_param[`ETL_IN_FWD_LSB+3:`ETL_IN_FWD_LSB]),
    .active_o(fwd_req_raw)
  );

  etl_term_sel u_rev_term (
    .term_i(in_term_i),
    .digit_i(input_assign_param[`ETL_IN_REV_LSB+3:`ETL_IN_REV_LSB]),
    .active_o(rev_req_raw)
  );

  // Registered so a terminal change reaches the clamp one cycle later
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fwd_ext_limit_req <= 1'b0;
      rev_ext_limit_req <= 1'b0;
    end else begin
      fwd_ext_limit_req <= fwd_req_raw;
      rev_ext_limit_req <= rev_req_raw;
    end
  end

  // ----------------------------------------------------------------
  // Limit selection
  // ----------------------------------------------------------------
  wire [`ETL_LIM_W-1:0] fwd_limit;
  wire [`ETL_LIM_W-1:0] rev_limit;

  etl_limit_sel u_fwd_lim (
    .int_lim_i(fwd_internal_limit),
    .ext_lim_i(fwd_external_limit),
    .ext_req_i(fwd_ext_limit_req),
    .motor_max_i(motor_max_i),
    .limit_o(fwd_limit)
  );

  // Reverse uses its own external setting, not the forward one
  etl_limit_sel u_rev_lim (
    .int_lim_i(rev_internal_limit),
    .ext_lim_i(rev_external_limit),
    .ext_req_i(rev_ext_limit_req),
    .motor_max_i(motor_max_i),
    .limit_o(rev_limit)
  );

  // ----------------------------------------------------------------
  // Torque clamp
  // ----------------------------------------------------------------
  reg is_fwd;
  reg [`ETL_TRQ_W-1:0] cmd_mag;
  reg [`ETL_TRQ_W-1:0] dir_lim;
  reg clamp;
  reg signed [`ETL_TRQ_W-1:0] next_trq;

  always @* begin
    // Direction select bit swaps which sign counts as forward
    is_fwd = (trq_cmd_i[`ETL_TRQ_W-1] == direction_select_param[0]);
    cmd_mag = trq_mag(trq_cmd_i);
    dir_lim = {2'b00, (is_fwd ? fwd_limit : rev_limit)};
    clamp = (cmd_mag > dir_lim);
    next_trq = trq_cmd_i;
    if (clamp) begin
      next_trq = trq_cmd_i[`ETL_TRQ_W-1] ? (~dir_lim + 12'h001) : dir_lim;
    end
  end

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trq_vld_o <= 1'b0;
      trq_out_o <= 12'h000;
      torque_limited_flag_o <= 1'b0;
    end else begin
      trq_vld_o <= trq_vld_i;
      if (trq_vld_i) begin
        trq_out_o <= next_trq;
        torque_limited_flag_o <= clamp;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output terminal routing
  // ----------------------------------------------------------------
  wire [3:0] out_digit;
  reg [`ETL_N_OUT_TERM-1:0] next_out_term;
  integer k;

  assign out_digit = output_assign_param[3:0];

  always @* begin
    next_out_term = {`ETL_N_OUT_TERM{1'b0}};
    for (k = 0; k < `ETL_N_OUT_TERM; k = k + 1) begin
      if (out_digit == k[3:0]) begin
        next_out_term[k] = torque_limited_flag_o;
      end
    end
  end

  // One cycle behind the flag, a terminal never glitches on reassignment
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_term_o <= {`ETL_N_OUT_TERM{1'b0}};
    end else begin
      out_term_o <= next_out_term;
    end
  end

  // ----------------------------------------------------------------
  // Encoder usage and start-up
  // ----------------------------------------------------------------
  reg started;
  reg [1:0] enc_mode;
  reg [1:0] next_mode;
  wire [3:0] usage_digit;

  assign usage_digit = encoder_usage_param[`ETL_ENC_LSB+3:`ETL_ENC_LSB];

  always @* begin
    case (usage_digit)
      `ETL_ENC_OWN: next_mode = enc_type_i;
      `ETL_ENC_INC: next_mode = `ETL_MODE_INC;
      `ETL_ENC_ABS1: begin
        // An incremental encoder cannot report an absolute turn
        next_mode = (enc_type_i == `ETL_MODE_INC) ? `ETL_MODE_INC : `ETL_MODE_ABS1;
      end
      default: next_mode = enc_type_i;
    endcase
  end

  // Mode is taken at the first edge after reset release or on a soft
  // restart; writes to the usage digit alone change nothing live
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      started <= 1'b0;
      enc_mode <= `ETL_MODE_INC;
    end else begin
      started <= 1'b1;
      if (!started || restart_req) begin
        enc_mode <= next_mode;
      end
    end
  end

  // ----------------------------------------------------------------
  // Position keeping
  // ----------------------------------------------------------------
  reg [31:0] position;
  reg [31:0] start_pos;

  always @* begin
    case (next_mode)
      `ETL_MODE_ABSM: start_pos = abs_pos_i;
      `ETL_MODE_ABS1: start_pos = {12'h000, abs_pos_i[`ETL_TURN_BITS-1:0]};
      default: start_pos = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      position <= 32'h0000_0000;
    end else if (!started || restart_req) begin
      position <= start_pos;
    end else if (pos_step_i) begin
      position <= pos_dir_i ? (position - 32'h0000_0001) : (position + 32'h0000_0001);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  reg [15:0] next_rdata;

  always @* begin
    case (addr_i)
      `ETL_A_FWD_INT: next_rdata = {6'h00, fwd_internal_limit};
      `ETL_A_REV_INT: next_rdata = {6'h00, rev_internal_limit};
      `ETL_A_FWD_EXT: next_rdata = {6'h00, fwd_external_limit};
      `ETL_A_REV_EXT: next_rdata = {6'h00, rev_external_limit};
      `ETL_A_IN_ASSIGN: next_rdata = input_assign_param;
      `ETL_A_OUT_ASSIGN: next_rdata = output_assign_param;
      `ETL_A_ENC_USAGE: next_rdata = encoder_usage_param;
      `ETL_A_STATUS: begin
        next_rdata = {10'h000, enc_mode, 1'b0, rev_ext_limit_req,
                      fwd_ext_limit_req, torque_limited_flag_o};
      end
      `ETL_A_POS_LO: next_rdata = position[15:0];
      `ETL_A_POS_HI: next_rdata = position[31:16];
      `ETL_A_DIR_SEL: next_rdata = direction_select_param;
      default: next_rdata = 16'h0000;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule // etl_top

// ==== etl_host_model.sv ====
// Host controller model: drives the two external limit requests onto
// input terminals. Assumes the bench says which requests are on.
`timescale 1ns/10ps
module etl_host_model #(
  parameter FWD_T = 2,
  parameter REV_T = 3
) (
  input wire logic core_clk_i,
  input wire logic fwd_on_i,
  input wire logic rev_on_i,
  output logic [7:0] term_o = 8'h00
);
  logic [7:0] noise = 8'h5a;
  // Unused terminals churn every cycle so a wrong terminal pick shows up
  always @(posedge core_clk_i) begin
    noise <= {noise[6:0], noise[7] ^ noise[5]};
    term_o <= noise;
    term_o[FWD_T] <= fwd_on_i;
    term_o[REV_T] <= rev_on_i;
  end
endmodule // etl_host_model

// ==== etl_chk.sv ====
// Checker for the torque limit select top: torque path, flag, read port.
// Assumes it is bound to etl_top and sees only its ports.
`timescale 1ns/10ps
module etl_chk (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [3:0] out_term_o,
  input wire logic [9:0] motor_max_i,
  input wire logic trq_vld_i,
  input wire logic signed [11:0] trq_cmd_i,
  input wire logic trq_vld_o,
  input wire logic signed [11:0] trq_out_o,
  input wire logic torque_limited_flag_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Magnitude so one cap check serves both directions
  wire [11:0] mag_out = trq_out_o[11] ? -trq_out_o : trq_out_o;
  wire cmd_neg = trq_cmd_i[11];
  a_vld_echo: assert property (trq_vld_i |=> trq_vld_o)
    else $error("result strobe missing");
  a_vld_quiet: assert property (!trq_vld_i |=> !trq_vld_o)
    else $error("result strobe without command");
  a_out_hold: assert property (!trq_vld_i |=> $stable(trq_out_o) &&
    $stable(torque_limited_flag_o)) else $error("torque output moved between commands");
  a_flag_clamp: assert property (trq_vld_o |->
    torque_limited_flag_o == (trq_out_o != $past(trq_cmd_i))) else $error("flag disagrees");
  a_motor_cap: assert property (trq_vld_o |-> mag_out <= {2'h0, $past(motor_max_i)})
    else $error("torque above motor maximum");
  a_sign_kept: assert property (trq_vld_o && trq_out_o != 12'sh000 |->
    trq_out_o[11] == $past(cmd_neg)) else $error("torque sign flipped");
  a_zero_free: assert property (trq_vld_i && trq_cmd_i == 12'sh000 |=>
    !torque_limited_flag_o) else $error("zero command flagged");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside read slot");
  a_term_flag: assert property ($onehot0(out_term_o) &&
    (out_term_o == 4'h0 || $past(torque_limited_flag_o))) else $error("terminal wrong");
  c_clamp: cover property ($rose(torque_limited_flag_o));
  c_read: cover property (rd_i ##1 rdata_o != 16'h0000);
  c_term: cover property (out_term_o != 4'h0);
endmodule // etl_chk

bind etl_top etl_chk u_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .out_term_o(out_term_o), .motor_max_i(motor_max_i),
  .trq_vld_i(trq_vld_i), .trq_cmd_i(trq_cmd_i), .trq_vld_o(trq_vld_o),
  .trq_out_o(trq_out_o), .torque_limited_flag_o(torque_limited_flag_o));

// ==== external_torque_limit_select_test.sv ====
// Self-checking bench for the torque limit select top.
// Assumes the checker binds itself and the host model drives terminals.
`timescale 1ns/10ps
`include "etl_regs.vh"
module external_torque_limit_select_test;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [9:0] motor_max_i = 10'h320;
  logic trq_vld_i = 1'b0;
  logic signed [11:0] trq_cmd_i = 12'sh000;
  logic pos_step_i = 1'b0;
  logic pos_dir_i = 1'b0;
  logic fwd_on = 1'b0;
  logic rev_on = 1'b0;
  logic [1:0] enc_type = 2'h2;
  wire [15:0] rdata_o;
  wire [7:0] in_term_i;
  wire [3:0] out_term_o;
  wire trq_vld_o;
  wire signed [11:0] trq_out_o;
  wire flag;
  int error_cnt = 0;
  int total_checks = 0;

  always #2.5 core_clk_i = ~core_clk_i;
  etl_host_model u_host (.core_clk_i(core_clk_i), .fwd_on_i(fwd_on), .rev_on_i(rev_on),
    .term_o(in_term_i));
  etl_top dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .in_term_i(in_term_i),
    .out_term_o(out_term_o), .motor_max_i(motor_max_i), .trq_vld_i(trq_vld_i),
    .trq_cmd_i(trq_cmd_i), .trq_vld_o(trq_vld_o), .trq_out_o(trq_out_o),
    .torque_limited_flag_o(flag), .enc_type_i(enc_type), .abs_pos_i(32'h123abcde),
    .pos_step_i(pos_step_i), .pos_dir_i(pos_dir_i));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  task automatic mode(input logic [1:0] e);
    logic [15:0] v;
    rd(`ETL_A_STATUS, v);
    chk({14'h0, v[5:4]}, {14'h0, e});
  endtask
  task automatic restart();
    wr(`ETL_A_CTRL, 16'h0001);
    repeat (3) @(posedge core_clk_i);
  endtask
  // One command, then the clamped result and the terminal a cycle later
  task automatic trq(input logic signed [11:0] c, input logic signed [11:0] e, input logic f);
    @(posedge core_clk_i);
    trq_vld_i <= 1'b1;
    trq_cmd_i <= c;
    @(posedge core_clk_i);
    trq_vld_i <= 1'b0;
    #1 chk({4'h0, trq_out_o}, {4'h0, e});
    chk({15'h0, flag}, {15'h0, f});
    chk({15'h0, trq_vld_o}, 16'h0001);
    @(posedge core_clk_i);
    #1 chk({12'h0, out_term_o}, {15'h0, f});
    chk({15'h0, trq_vld_o}, 16'h0000);
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc(`ETL_A_FWD_INT, 16'h0320);
    rdc(`ETL_A_REV_INT, 16'h0320);
    rdc(`ETL_A_FWD_EXT, 16'h0064);
    rdc(`ETL_A_REV_EXT, 16'h0064);
    rdc(`ETL_A_IN_ASSIGN, 16'h8800);
    rdc(`ETL_A_OUT_ASSIGN, 16'h0000);
    rdc(`ETL_A_STATUS, 16'h0020);
    rdc(`ETL_A_POS_HI, 16'h123a);
    rdc(4'hc, 16'h0000);
    wr(`ETL_A_FWD_INT, 16'h03ff);
    rdc(`ETL_A_FWD_INT, 16'h0320);
    wr(`ETL_A_REV_EXT, 16'h0321);
    rdc(`ETL_A_REV_EXT, 16'h0320);
    $display("reset and range test done");
  endtask
  task automatic t_limits();
    wr(`ETL_A_FWD_INT, 16'h012c);
    wr(`ETL_A_REV_INT, 16'h00c8);
    trq(12'sd500, 12'sd300, 1'b1);
    trq(-12'sd500, -12'sd200, 1'b1);
    trq(12'sd300, 12'sd300, 1'b0);
    trq(-12'sd199, -12'sd199, 1'b0);
    wr(`ETL_A_FWD_EXT, 16'h0096);
    wr(`ETL_A_REV_EXT, 16'h00fa);
    wr(`ETL_A_IN_ASSIGN, 16'h3200);
    fwd_on <= 1'b1;
    settle();
    trq(12'sd500, 12'sd150, 1'b1);
    trq(-12'sd500, -12'sd200, 1'b1);
    @(posedge core_clk_i);
    fwd_on <= 1'b0;
    rev_on <= 1'b1;
    settle();
    rdc(`ETL_A_STATUS, 16'h0025);
    trq(12'sd500, 12'sd300, 1'b1);
    trq(-12'sd500, -12'sd200, 1'b1);
    wr(`ETL_A_REV_EXT, 16'h0032);
    trq(-12'sd500, -12'sd50, 1'b1);
    @(posedge core_clk_i);
    rev_on <= 1'b0;
    settle();
    motor_max_i <= 10'h064;
    trq(12'sd500, 12'sd100, 1'b1);
    trq(-12'sd100, -12'sd100, 1'b0);
    @(posedge core_clk_i);
    motor_max_i <= 10'h320;
    wr(`ETL_A_DIR_SEL, 16'h0001);
    trq(-12'sd500, -12'sd300, 1'b1);
    trq(12'sd500, 12'sd200, 1'b1);
    wr(`ETL_A_DIR_SEL, 16'h0000);
    // Flag is still set here, so a moved terminal must carry it
    wr(`ETL_A_OUT_ASSIGN, 16'h0002);
    @(posedge core_clk_i);
    #1 chk({12'h0, out_term_o}, 16'h0004);
    wr(`ETL_A_OUT_ASSIGN, 16'h0004);
    @(posedge core_clk_i);
    #1 chk({12'h0, out_term_o}, 16'h0000);
    wr(`ETL_A_OUT_ASSIGN, 16'h0000);
    wr(`ETL_A_FWD_INT, 16'h0000);
    trq(12'sd0, 12'sd0, 1'b0);
    trq(12'sd1, 12'sd0, 1'b1);
    $display("limit selection test done");
  endtask
  task automatic t_encoder();
    wr(`ETL_A_ENC_USAGE, 16'h0200);
    mode(`ETL_MODE_ABSM);
    restart();
    mode(`ETL_MODE_ABS1);
    rdc(`ETL_A_POS_HI, 16'h000a);
    @(posedge core_clk_i);
    pos_dir_i <= 1'b1;
    pos_step_i <= 1'b1;
    @(posedge core_clk_i);
    pos_step_i <= 1'b0;
    rdc(`ETL_A_POS_LO, 16'hbcdd);
    wr(`ETL_A_ENC_USAGE, 16'h0100);
    restart();
    mode(`ETL_MODE_INC);
    rdc(`ETL_A_POS_LO, 16'h0000);
    wr(`ETL_A_ENC_USAGE, 16'h0000);
    restart();
    rdc(`ETL_A_POS_LO, 16'hbcde);
    rdc(`ETL_A_POS_HI, 16'h123a);
    wr(`ETL_A_ENC_USAGE, 16'h0200);
    enc_type <= `ETL_MODE_INC;
    restart();
    mode(`ETL_MODE_INC);
    wr(`ETL_A_ENC_USAGE, 16'h0000);
    enc_type <= `ETL_MODE_ABS1;
    restart();
    mode(`ETL_MODE_ABS1);
    rdc(`ETL_A_POS_HI, 16'h000a);
    $display("encoder usage test done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_limits();
    t_encoder();
    test_done();
  end
  // Guards against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge core_clk_i);
    error_cnt++;
    $display("[ERR] t=%0t run did not finish", $time);
    test_done();
  end
endmodule // external_torque_limit_select_test
